// >>> hw/uldc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ULDC_REGS_SVH
`define ULDC_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ULDC_CTRL_OFS     8'h00
`define ULDC_BAUD_OFS     8'h04
`define ULDC_TXDATA_OFS   8'h08
`define ULDC_RXDATA_OFS   8'h0c
`define ULDC_STATUS_OFS   8'h10
`define ULDC_MASK_OFS     8'h14
`define ULDC_LINE_OFS     8'h18

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define ULDC_CTRL_NINE    0
`define ULDC_CTRL_PAR_EN  1
`define ULDC_CTRL_PAR_ODD 2
`define ULDC_CTRL_TWO_STP 3
`define ULDC_CTRL_HALF    4
`define ULDC_CTRL_AUTO    5
`define ULDC_CTRL_DIR_SW  6
`define ULDC_CTRL_P2P     7
`define ULDC_CTRL_W       8

// ----------------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------------
`define ULDC_ST_RX_DONE   0
`define ULDC_ST_TX_DONE   1
`define ULDC_ST_PAR_ERR   2
`define ULDC_ST_FRM_ERR   3
`define ULDC_ST_OVERRUN   4
`define ULDC_ST_ECHO_ERR  5
`define ULDC_ST_TX_DROP   6
`define ULDC_ST_W         7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ULDC_CTRL_RST     8'h40
`define ULDC_BAUD_RST     16'h0411
`define ULDC_MASK_RST     7'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ULDC_CLK_HZ       10000000
`define ULDC_MAX_BAUD     115200
`define ULDC_MIN_DIV      \
  16'((`ULDC_CLK_HZ + `ULDC_MAX_BAUD - 1) / `ULDC_MAX_BAUD)

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define ULDC_RESP_OKAY    2'b00
`define ULDC_RESP_SLVERR  2'b10

`endif

// >>> hw/uldc_pkg.sv
// types shared by the serial line controller modules
package uldc_pkg;

  // character format
  typedef struct packed {
    logic nine;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } uldc_fmt_t;

  // frame state for both shifters
  typedef enum logic [2:0] {
    ULDC_IDLE  = 3'b000,
    ULDC_START = 3'b001,
    ULDC_DATA  = 3'b010,
    ULDC_PAR   = 3'b011,
    ULDC_STOP  = 3'b100
  } uldc_state_t;

  // received character with its checks
  typedef struct packed {
    logic [8:0] data;
    logic       done;
    logic       perr;
    logic       ferr;
  } uldc_rx_res_t;

endpackage

// >>> hw/uldc_tx.sv
// serial transmit shifter
`timescale 1ns/1ns
`default_nettype none
module uldc_tx (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [15:0]       div,
  input  wire uldc_pkg::uldc_fmt_t fmt,
  input  wire logic              start,
  input  wire logic [8:0]        data,
  output var  logic              line,
  output var  logic              busy,
  output var  logic              done
);
  uldc_pkg::uldc_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [3:0]  bit_reg;
  logic [8:0]  sh_reg;
  logic        par_reg;
  logic        tick;
  logic [8:0]  dmask;

  assign tick  = (cnt_reg == div - 16'h0001);
  assign dmask = fmt.nine ? data : {1'b0, data[7:0]};
  assign busy  = (state_reg != uldc_pkg::ULDC_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n || state_reg == uldc_pkg::ULDC_IDLE || tick) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      state_reg <= uldc_pkg::ULDC_IDLE;
      line      <= 1'b1;
      bit_reg   <= 4'h0;
      sh_reg    <= 9'h000;
      par_reg   <= 1'b0;
    end else begin
      case (state_reg)
        uldc_pkg::ULDC_IDLE: begin
          line <= 1'b1;
          if (start) begin
            sh_reg    <= dmask;
            par_reg   <= fmt.par_odd ? ~(^dmask) : ^dmask;
            line      <= 1'b0;
            state_reg <= uldc_pkg::ULDC_START;
          end
        end
        uldc_pkg::ULDC_START: begin
          if (tick) begin
            line      <= sh_reg[0];
            bit_reg   <= 4'h0;
            state_reg <= uldc_pkg::ULDC_DATA;
          end
        end
        uldc_pkg::ULDC_DATA: begin
          if (tick) begin
            sh_reg  <= {1'b0, sh_reg[8:1]};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == (fmt.nine ? 4'h8 : 4'h7)) begin
              bit_reg   <= 4'h0;
              line      <= fmt.par_en ? par_reg : 1'b1;
              state_reg <= fmt.par_en ? uldc_pkg::ULDC_PAR
                                      : uldc_pkg::ULDC_STOP;
            end else begin
              line <= sh_reg[1];
            end
          end
        end
        uldc_pkg::ULDC_PAR: begin
          if (tick) begin
            line      <= 1'b1;
            state_reg <= uldc_pkg::ULDC_STOP;
          end
        end
        uldc_pkg::ULDC_STOP: begin
          if (tick) begin
            if (fmt.two_stop && bit_reg == 4'h0) begin
              bit_reg <= 4'h1;
            end else begin
              done      <= 1'b1;
              state_reg <= uldc_pkg::ULDC_IDLE;
            end
          end
        end
        default: begin
          state_reg <= uldc_pkg::ULDC_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hw/uldc_rx.sv
// serial receive shifter with parity and stop checks
`timescale 1ns/1ns
`default_nettype none
module uldc_rx (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [15:0]         div,
  input  wire uldc_pkg::uldc_fmt_t fmt,
  input  wire logic                line,
  output var  uldc_pkg::uldc_rx_res_t res
);
  uldc_pkg::uldc_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [3:0]  bit_reg;
  logic [8:0]  sh_reg;
  logic        perr_reg;
  logic        ferr_reg;
  logic        tick;
  logic        half;

  assign tick = (cnt_reg == div - 16'h0001);
  assign half = (cnt_reg == {1'b0, div[15:1]} - 16'h0001);

  always_ff @(posedge clk) begin
    if (!rst_n || state_reg == uldc_pkg::ULDC_IDLE || tick ||
        (state_reg == uldc_pkg::ULDC_START && half)) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    res.done <= 1'b0;
    if (!rst_n) begin
      state_reg <= uldc_pkg::ULDC_IDLE;
      bit_reg   <= 4'h0;
      sh_reg    <= 9'h000;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
      res       <= '0;
    end else begin
      case (state_reg)
        uldc_pkg::ULDC_IDLE: begin
          if (!line) begin
            state_reg <= uldc_pkg::ULDC_START;
          end
        end
        uldc_pkg::ULDC_START: begin
          if (half) begin
            bit_reg   <= 4'h0;
            sh_reg    <= 9'h000;
            perr_reg  <= 1'b0;
            ferr_reg  <= 1'b0;
            state_reg <= line ? uldc_pkg::ULDC_IDLE : uldc_pkg::ULDC_DATA;
          end
        end
        uldc_pkg::ULDC_DATA: begin
          if (tick) begin
            sh_reg[bit_reg] <= line;
            bit_reg         <= bit_reg + 4'h1;
            if (bit_reg == (fmt.nine ? 4'h8 : 4'h7)) begin
              bit_reg   <= 4'h0;
              state_reg <= fmt.par_en ? uldc_pkg::ULDC_PAR
                                      : uldc_pkg::ULDC_STOP;
            end
          end
        end
        uldc_pkg::ULDC_PAR: begin
          if (tick) begin
            perr_reg  <= line ^ (fmt.par_odd ? ~(^sh_reg) : ^sh_reg);
            state_reg <= uldc_pkg::ULDC_STOP;
          end
        end
        uldc_pkg::ULDC_STOP: begin
          if (tick) begin
            if (!line) begin
              ferr_reg <= 1'b1;
            end
            if (fmt.two_stop && bit_reg == 4'h0) begin
              bit_reg <= 4'h1;
            end else begin
              res.data  <= sh_reg;
              res.done  <= 1'b1;
              res.perr  <= perr_reg;
              res.ferr  <= ferr_reg | ~line;
              state_reg <= uldc_pkg::ULDC_IDLE;
            end
          end
        end
        default: begin
          state_reg <= uldc_pkg::ULDC_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hw/uldc_top.sv
// serial line controller with line direction control, axi4-lite slave
// ----------------------------------------------------------------------
// Contract
// - 8/9 data bits, even/odd/no parity, 1/2 stops
// - programmable baud divisor, up to 115200 baud
// - full duplex: direction low enables transmit driver
// - half duplex: direction low transmits, high receives
// - point to point may hold direction low
// - full duplex only: override gates direction; off keeps driver enabled
// - receiver stays active while transmitting, echoing
// - direction held high during reset
// ----------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "uldc_regs.svh"
module uldc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        rxd,
  output var  logic        txd,
  output var  logic        second_pulse_output,
  input  wire logic        direction_override_switch,
  output var  logic        driver_enable_n,
  output var  logic        irq
);

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  logic [7:0]                 aw_addr_reg;
  logic [31:0]                w_data_reg;
  logic [31:0]                w_mask_reg;
  logic                       aw_full_reg;
  logic                       w_full_reg;
  logic                       wr_fire;
  logic                       rd_fire;
  logic [31:0]                rd_data_next;
  logic                       rd_hit_next;
  logic [`ULDC_CTRL_W-1:0]    ctrl_reg;
  logic [15:0]                baud_reg;
  logic [15:0]                baud_next;
  logic [`ULDC_ST_W-1:0]      status_reg;
  logic [`ULDC_ST_W-1:0]      mask_reg;
  logic [`ULDC_ST_W-1:0]      events;
  logic [8:0]                 hold_reg;
  logic                       hold_full_reg;
  logic [8:0]                 last_tx_reg;
  logic [8:0]                 rx_data_reg;
  logic                       rx_valid_reg;
  logic                       dir_reg;
  logic                       dir_next;
  logic                       tx_go;
  logic                       tx_line;
  logic                       tx_busy;
  logic                       tx_done;
  logic                       wr_tx;
  logic                       rd_rx;
  logic [8:0]                 char_mask;
  uldc_pkg::uldc_fmt_t        fmt;
  uldc_pkg::uldc_rx_res_t     rx_res;

  assign fmt.nine     = ctrl_reg[`ULDC_CTRL_NINE];
  assign fmt.par_en   = ctrl_reg[`ULDC_CTRL_PAR_EN];
  assign fmt.par_odd  = ctrl_reg[`ULDC_CTRL_PAR_ODD];
  assign fmt.two_stop = ctrl_reg[`ULDC_CTRL_TWO_STP];
  assign char_mask    = fmt.nine ? 9'h1ff : 9'h0ff;

  // --------------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------------
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid;
  assign wr_tx   = wr_fire && (aw_addr_reg == `ULDC_TXDATA_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_mask_reg  <= 32'h0000_0000;
      bvalid      <= 1'b0;
      bresp       <= `ULDC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        aw_full_reg <= 1'b1;
        awready     <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_mask_reg <= {{8{wstrb[3]}}, {8{wstrb[2]}},
                       {8{wstrb[1]}}, {8{wstrb[0]}}};
        w_full_reg <= 1'b1;
        wready     <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        case (aw_addr_reg)
          `ULDC_CTRL_OFS, `ULDC_BAUD_OFS, `ULDC_TXDATA_OFS,
          `ULDC_STATUS_OFS, `ULDC_MASK_OFS: begin
            bresp <= `ULDC_RESP_OKAY;
          end
          default: begin
            bresp <= `ULDC_RESP_SLVERR;
          end
        endcase
      end
      if (bvalid && bready) begin
        bvalid      <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        awready     <= 1'b1;
        wready      <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------------
  assign rd_fire = arvalid & arready;
  assign rd_rx   = rd_fire && (araddr == `ULDC_RXDATA_OFS);

  always_comb begin
    rd_data_next = 32'h0000_0000;
    rd_hit_next  = 1'b1;
    case (araddr)
      `ULDC_CTRL_OFS:   rd_data_next[`ULDC_CTRL_W-1:0] = ctrl_reg;
      `ULDC_BAUD_OFS:   rd_data_next[15:0] = baud_reg;
      `ULDC_TXDATA_OFS: rd_data_next[8:0] = hold_reg;
      `ULDC_RXDATA_OFS: rd_data_next[8:0] = rx_data_reg;
      `ULDC_STATUS_OFS: rd_data_next[`ULDC_ST_W-1:0] = status_reg;
      `ULDC_MASK_OFS:   rd_data_next[`ULDC_ST_W-1:0] = mask_reg;
      `ULDC_LINE_OFS: begin
        rd_data_next[4:0] = {direction_override_switch, dir_reg,
                             rx_valid_reg, hold_full_reg, tx_busy};
      end
      default: begin
        rd_hit_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `ULDC_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data_next;
        rresp   <= rd_hit_next ? `ULDC_RESP_OKAY : `ULDC_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // control, baud and mask registers
  // --------------------------------------------------------------------
  always_comb begin
    baud_next = (baud_reg & ~w_mask_reg[15:0]) |
                (w_data_reg[15:0] & w_mask_reg[15:0]);
    if (baud_next < `ULDC_MIN_DIV) begin
      baud_next = `ULDC_MIN_DIV;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `ULDC_CTRL_RST;
      baud_reg <= `ULDC_BAUD_RST;
      mask_reg <= `ULDC_MASK_RST;
    end else if (wr_fire) begin
      if (aw_addr_reg == `ULDC_CTRL_OFS && wstrb_lane0()) begin
        ctrl_reg <= w_data_reg[`ULDC_CTRL_W-1:0];
      end
      if (aw_addr_reg == `ULDC_BAUD_OFS) begin
        baud_reg <= baud_next;
      end
      if (aw_addr_reg == `ULDC_MASK_OFS && wstrb_lane0()) begin
        mask_reg <= w_data_reg[`ULDC_ST_W-1:0];
      end
    end
  end

  function automatic logic wstrb_lane0();
    wstrb_lane0 = w_mask_reg[0];
  endfunction

  // --------------------------------------------------------------------
  // transmit holding register
  // --------------------------------------------------------------------
  assign tx_go = hold_full_reg & ~tx_busy &
                 (~ctrl_reg[`ULDC_CTRL_AUTO] | ~dir_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg      <= 9'h000;
      hold_full_reg <= 1'b0;
      last_tx_reg   <= 9'h000;
    end else begin
      if (tx_go) begin
        hold_full_reg <= 1'b0;
        last_tx_reg   <= hold_reg & char_mask;
      end
      if (wr_tx && !hold_full_reg && w_mask_reg[0]) begin
        hold_reg      <= w_data_reg[8:0];
        hold_full_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // line direction
  // --------------------------------------------------------------------
  always_comb begin
    if (ctrl_reg[`ULDC_CTRL_P2P]) begin
      dir_next = 1'b0;
    end else if (ctrl_reg[`ULDC_CTRL_AUTO]) begin
      dir_next = ~(hold_full_reg | tx_busy | tx_go);
    end else begin
      dir_next = ctrl_reg[`ULDC_CTRL_DIR_SW];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg             <= 1'b1;
      second_pulse_output <= 1'b1;
      driver_enable_n     <= 1'b1;
    end else begin
      dir_reg             <= dir_next;
      second_pulse_output <= dir_next;
      if (!direction_override_switch && !ctrl_reg[`ULDC_CTRL_HALF]) begin
        driver_enable_n <= 1'b0;
      end else begin
        driver_enable_n <= dir_next;
      end
    end
  end

  // --------------------------------------------------------------------
  // shifters
  // --------------------------------------------------------------------
  uldc_tx u_tx (
    .clk   (aclk),
    .rst_n (aresetn),
    .div   (baud_reg),
    .fmt   (fmt),
    .start (tx_go),
    .data  (hold_reg),
    .line  (tx_line),
    .busy  (tx_busy),
    .done  (tx_done)
  );

  // receiver never gated by direction so echoes come back
  uldc_rx u_rx (
    .clk   (aclk),
    .rst_n (aresetn),
    .div   (baud_reg),
    .fmt   (fmt),
    .line  (rxd),
    .res   (rx_res)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd <= 1'b1;
    end else begin
      txd <= tx_line;
    end
  end

  // --------------------------------------------------------------------
  // receive data register
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_reg  <= 9'h000;
      rx_valid_reg <= 1'b0;
    end else begin
      if (rd_rx) begin
        rx_valid_reg <= 1'b0;
      end
      if (rx_res.done) begin
        rx_data_reg  <= rx_res.data;
        rx_valid_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // events, sticky status and interrupt
  // --------------------------------------------------------------------
  always_comb begin
    events = '0;
    events[`ULDC_ST_RX_DONE]  = rx_res.done;
    events[`ULDC_ST_TX_DONE]  = tx_done;
    events[`ULDC_ST_PAR_ERR]  = rx_res.done & rx_res.perr;
    events[`ULDC_ST_FRM_ERR]  = rx_res.done & rx_res.ferr;
    events[`ULDC_ST_OVERRUN]  = rx_res.done & rx_valid_reg & ~rd_rx;
    events[`ULDC_ST_ECHO_ERR] = rx_res.done & ctrl_reg[`ULDC_CTRL_HALF] &
                                (rx_res.data != last_tx_reg);
    events[`ULDC_ST_TX_DROP]  = wr_tx & hold_full_reg;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else if (wr_fire && aw_addr_reg == `ULDC_STATUS_OFS &&
                 w_mask_reg[0]) begin
      status_reg <= (status_reg & ~w_data_reg[`ULDC_ST_W-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

endmodule
`default_nettype wire

// >>> sim/uldc_monitor.sv
// port-level checks for the serial line controller
`timescale 1ns/1ns
`default_nettype none
module uldc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic txd,
  input wire logic second_pulse_output,
  input wire logic driver_enable_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rst_dir;
    $rose(aresetn) |-> second_pulse_output && driver_enable_n;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("dir low");

  property p_drv;
    driver_enable_n |-> second_pulse_output;
  endproperty
  a_drv: assert property (p_drv) else $error("driver off");

  // shortest bit time is 87 clocks
  property p_start;
    $fell(txd) |-> !txd [*8];
  endproperty
  a_start: assert property (p_start) else $error("short start");

  property p_release;
    $rose(second_pulse_output) |-> txd && $past(txd, 80);
  endproperty
  a_release: assert property (p_release) else $error("early");

  property p_wr_ans;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no bvalid");

  property p_rd_ans;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");

  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("b stuck");

  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("r stuck");
endmodule
`default_nettype wire

// >>> sim/uldc_node.sv
// remote serial node on the line pair
`timescale 1ns/1ns
`default_nettype none
module uldc_node (
  input  wire logic aclk,
  input  wire logic txd,
  input  wire logic second_pulse_output,
  output var  logic rxd
);
  logic echo    = 1'b0;
  logic node_tx = 1'b1;

  // shared pair carries our own driver while it transmits
  always_comb rxd = (echo && !second_pulse_output) ? txd : node_tx;

  // bits lsb first, div clocks each; idle mark afterwards
  task automatic send(logic [12:0] b, int n, int div);
    for (int i = 0; i < n; i++) begin
      node_tx <= b[i];
      repeat (div) @(posedge aclk);
    end
    node_tx <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// bench for the serial line controller
`timescale 1ns/1ns
`default_nettype none
`include "uldc_regs.svh"
module testbench;
  localparam int DIV   = 87;
  localparam int FRAME = 11 * DIV;
  localparam logic [8:0] NINE_CH = 9'h1c3;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        direction_override_switch = 1'b1;
  logic [3:0]  wstrb   = 4'hf;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
  logic        second_pulse_output, driver_enable_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          cnt;
  logic [7:0]  dc [5] = '{8'h40, 8'h00, 8'h40, 8'h50, 8'hc0};
  logic [1:0]  ex [5] = '{2'b11, 2'b00, 2'b10, 2'b11, 2'b00};
  logic [4:0]  ovr    = 5'b11011;

  uldc_top  uldc_top_i (.*);
  uldc_node uldc_node_i (.*);

  always #50 aclk = ~aclk;

  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tmo;
    n_mismatch++;
    report_and_stop;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e = 2'b00);
    int t;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (t == 40) tmo;
    chk("bresp", 32'(bresp), 32'(e));
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(logic [7:0] a, logic [31:0] e, logic [1:0] r = 2'b00);
    int t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (t == 40) tmo;
    chk("rdata", rdata, e);
    chk("rresp", 32'(rresp), 32'(r));
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_dir(logic v, int lim);
    cnt = 0;
    while (second_pulse_output !== v) begin
      @(posedge aclk);
      cnt++;
      if (cnt > lim) tmo;
    end
  endtask

  task automatic rx_case(logic [7:0] c, logic [12:0] b, int n,
                         logic [8:0] d, logic [6:0] s);
    wr(`ULDC_CTRL_OFS, {24'h0, c});
    uldc_node_i.send(b, n, DIV);
    rc(`ULDC_RXDATA_OFS, {23'h0, d});
    rc(`ULDC_STATUS_OFS, {25'h0, s});
    wr(`ULDC_STATUS_OFS, 32'h7f);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    chk("direction", 32'(second_pulse_output), 32'h1);
    chk("driver", 32'(driver_enable_n), 32'h1);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`ULDC_CTRL_OFS, 32'h40);
    rc(`ULDC_BAUD_OFS, 32'h411);
    rc(`ULDC_MASK_OFS, 32'h0);
    rc(`ULDC_STATUS_OFS, 32'h0);
    rc(8'h1c, 32'h0, 2'b10);
    wr(8'h1c, 32'h1, 2'b10);
    wr(`ULDC_BAUD_OFS, 32'(DIV));
    rc(`ULDC_BAUD_OFS, 32'(DIV));
    // half duplex, automatic direction, even parity, echo on the pair
    wr(`ULDC_CTRL_OFS, 32'h32);
    uldc_node_i.echo <= 1'b1;
    wr(`ULDC_TXDATA_OFS, 32'ha5);
    wait_dir(1'b0, 20);
    wait_dir(1'b1, 1500);
    chk("low time", 32'(cnt inside {[FRAME-4:FRAME+DIV-1]}), 32'h1);
    rc(`ULDC_STATUS_OFS, 32'h3);
    chk("irq", 32'(irq), 32'h0);
    wr(`ULDC_MASK_OFS, 32'h3);
    rc(`ULDC_RXDATA_OFS, 32'ha5);
    chk("irq", 32'(irq), 32'h1);
    wr(`ULDC_STATUS_OFS, 32'h3);
    rc(`ULDC_STATUS_OFS, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    uldc_node_i.echo <= 1'b0;
    rx_case(8'h4f, {2'b11, ~^NINE_CH, NINE_CH, 1'b0}, 13, NINE_CH, 7'h01);
    rx_case(8'h4f, {2'b11, ^NINE_CH, NINE_CH, 1'b0}, 13, NINE_CH, 7'h05);
    // half duplex: foreign character differs from last sent one
    rx_case(8'h50, {4'hf, 8'h3c, 1'b0}, 10, 9'h03c, 7'h21);
    for (int i = 0; i < 5; i++) begin
      direction_override_switch <= ovr[i];
      wr(`ULDC_CTRL_OFS, {24'h0, dc[i]});
      repeat (2) @(posedge aclk);
      chk("direction", 32'(second_pulse_output), 32'(ex[i][1]));
      chk("driver", 32'(driver_enable_n), 32'(ex[i][0]));
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("direction", 32'(second_pulse_output), 32'h1);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`ULDC_CTRL_OFS, 32'h40);
    report_and_stop;
  end
endmodule

bind uldc_top uldc_monitor uldc_monitor_i (.*);
`default_nettype wire
